// File: rtl/ext_bus_pkg.sv
// shared constants, register layout and state encoding of the external bus controller
package ext_bus_pkg;

   // external bus geometry
   localparam int EXT_ADDR_W = 16;
   localparam int EXT_DATA_W = 8;
   localparam int REG_ADDR_W = 8;

   // register byte offsets on the AXI4-Lite slave
   localparam logic [REG_ADDR_W-1:0] OFS_EXTERNAL_BUS_CONTROL = 8'h00;
   localparam logic [REG_ADDR_W-1:0] OFS_WAIT_STATE_CONTROL   = 8'h04;
   localparam logic [REG_ADDR_W-1:0] OFS_SYSTEM_CONTROL       = 8'h08;
   localparam logic [REG_ADDR_W-1:0] OFS_BUS_STATUS           = 8'h0C;

   // reset values
   localparam logic [7:0] EXTERNAL_BUS_CONTROL_RST = 8'hD3;
   localparam logic [7:0] WAIT_STATE_CONTROL_RST   = 8'hF3;
   localparam logic [7:0] SYSTEM_CONTROL_RST       = 8'h00;

   // external_bus_control fields
   localparam int BIT_IDLE_INSERT_AFTER_READ = 6;
   localparam int BIT_BURST_ROM_ENABLE       = 5;
   localparam int BIT_BURST_CYCLE_LENGTH_SEL = 4;
   localparam int BIT_BURST_WORD_LIMIT_SEL   = 3;
   localparam int BIT_IO_RANGE_SELECT_HI     = 1;
   localparam int BIT_IO_RANGE_SELECT_LO     = 0;

   // wait_state_control fields
   localparam int BIT_ACCESS_STATE_SEL      = 4;
   localparam int BIT_WAIT_MODE_SEL_HI      = 3;
   localparam int BIT_WAIT_MODE_SEL_LO      = 2;
   localparam int BIT_PROGRAM_WAIT_COUNT_HI = 1;
   localparam int BIT_PROGRAM_WAIT_COUNT_LO = 0;

   // system_control fields
   localparam int BIT_PIN_FUNCTION_IO_MODE = 0;

   // wait modes of a 3-state access
   localparam logic [1:0] WAIT_MODE_PROGRAM  = 2'h0;
   localparam logic [1:0] WAIT_MODE_DISABLED = 2'h1;
   localparam logic [1:0] WAIT_MODE_PIN      = 2'h2;
   localparam logic [1:0] WAIT_MODE_PIN_AUTO = 2'h3;

   // burst word limits, as index of the last word
   localparam logic [2:0] BURST_LAST_4 = 3'h3;
   localparam logic [2:0] BURST_LAST_8 = 3'h7;

   // upper address byte of each io select window, indexed by the range field
   localparam logic [7:0] IO_PAGE_0 = 8'hFC;
   localparam logic [7:0] IO_PAGE_1 = 8'hFD;
   localparam logic [7:0] IO_PAGE_2 = 8'hFE;
   localparam logic [7:0] IO_PAGE_3 = 8'hFF;

   // AXI responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [7:0] {
      ST_IDLE  = 8'b0000_0001,
      ST_GAP   = 8'b0000_0010,
      ST_T1    = 8'b0000_0100,
      ST_T2    = 8'b0000_1000,
      ST_TW    = 8'b0001_0000,
      ST_T3    = 8'b0010_0000,
      ST_BHOLD = 8'b0100_0000,
      ST_BURST = 8'b1000_0000
   } bus_state_type;

endpackage

// File: rtl/external_bus_controller.sv
// external bus controller: register slave, cpu/transfer arbiter and external cycle sequencer
//
// Operation
// - io mode bit clear: shared strobe pin marks valid address on every access.
// - io mode bit set: shared strobe pin asserts only inside chosen io range.
// - read strobe low throughout every external read cycle.
// - store strobe low on writes; data bus driven during write cycles.
// - idle bit set: one idle state between read and following write.
// - control bit 5 picks basic bus or burst rom interface.
// - control bit 4 picks one or two states per burst cycle.
// - control bit 3 limits a burst to four or eight words.
// - two-bit io range field picks where io select strobe asserts.
// - basic interface offers 2-state or 3-state access with program waits.
// - arbiter grants cpu or transfer controller, never both.
// - 2-state access inserts no waits of any kind.
// - wait mode field: program, disabled, pin, pin auto-wait.
// - wait count field inserts zero to three program waits; reset gives three.
//
// Our own choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/10ps
module external_bus_controller
   import ext_bus_pkg::*;
(
   input  wire logic                  aclk,
   input  wire logic                  aresetn,
   input  wire logic [REG_ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                  s_axi_awvalid,
   output logic                       s_axi_awready,
   input  wire logic [31:0]           s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   input  wire logic                  s_axi_wvalid,
   output logic                       s_axi_wready,
   output logic [1:0]                 s_axi_bresp,
   output logic                       s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   input  wire logic [REG_ADDR_W-1:0] s_axi_araddr,
   input  wire logic                  s_axi_arvalid,
   output logic                       s_axi_arready,
   output logic [31:0]                s_axi_rdata,
   output logic [1:0]                 s_axi_rresp,
   output logic                       s_axi_rvalid,
   input  wire logic                  s_axi_rready,
   input  wire logic                  cpu_req,
   input  wire logic                  cpu_write,
   input  wire logic [EXT_ADDR_W-1:0] cpu_addr,
   input  wire logic [EXT_DATA_W-1:0] cpu_wdata,
   output logic                       cpu_ack,
   output logic [EXT_DATA_W-1:0]      cpu_rdata,
   output logic                       cpu_grant,
   input  wire logic                  dtc_req,
   input  wire logic                  dtc_write,
   input  wire logic [EXT_ADDR_W-1:0] dtc_addr,
   input  wire logic [EXT_DATA_W-1:0] dtc_wdata,
   output logic                       dtc_ack,
   output logic [EXT_DATA_W-1:0]      dtc_rdata,
   output logic                       dtc_grant,
   output logic [EXT_ADDR_W-1:0]      ext_addr,
   output logic [EXT_DATA_W-1:0]      ext_data_out,
   output logic                       ext_data_oe,
   input  wire logic [EXT_DATA_W-1:0] ext_data_in,
   output logic                       addr_io_strobe_n,
   output logic                       read_strobe_n,
   output logic                       store_strobe_n,
   input  wire logic                  wait_request_n
);

   ////////////////////////////////////////////////////////////////////////////
   // declarations

   logic [7:0]            external_bus_control;
   logic [7:0]            wait_state_control;
   logic [7:0]            system_control;
   logic [REG_ADDR_W-1:0] aw_addr;
   logic [7:0]            w_byte;
   logic                  w_lane0;
   bus_state_type         state;
   bus_state_type         next_state;
   logic [1:0]            wait_cnt;
   logic [1:0]            next_wait_cnt;
   logic [2:0]            beat;
   logic [2:0]            next_beat;
   logic                  bphase;
   logic                  next_bphase;
   logic                  cur_we;
   logic                  last_read;
   logic                  wait_meta_n;
   logic                  wait_sync_n;
   logic                  pick_dtc;
   logic                  r_req;
   logic                  r_we;
   logic [EXT_ADDR_W-1:0] r_addr;
   logic [EXT_DATA_W-1:0] r_wdata;
   logic                  ack_pend;
   logic                  done;
   logic                  load;
   logic                  next_we;
   logic [EXT_ADDR_W-1:0] next_addr;
   logic                  active;
   logic                  write_phase;
   logic                  three_state;
   logic [1:0]            wait_mode;
   logic                  prog_waits;
   logic                  pin_waits;
   logic                  wait_pin;
   logic [2:0]            burst_last;
   logic                  burst_ok;

   // io select window hit for the chosen range
   function automatic logic io_hit(input logic [EXT_ADDR_W-1:0] a, input logic [1:0] sel);
      logic [7:0] page;
      page = IO_PAGE_0;
      unique case (sel)
         2'h0: page = IO_PAGE_0;
         2'h1: page = IO_PAGE_1;
         2'h2: page = IO_PAGE_2;
         2'h3: page = IO_PAGE_3;
      endcase
      return a[EXT_ADDR_W-1:EXT_ADDR_W-8] == page;
   endfunction

   // two addresses lie in one aligned burst block of four or eight words
   function automatic logic same_block(input logic [EXT_ADDR_W-1:0] a,
                                       input logic [EXT_ADDR_W-1:0] b,
                                       input logic                  eight);
      if (eight) begin
         return a[EXT_ADDR_W-1:3] == b[EXT_ADDR_W-1:3];
      end
      return a[EXT_ADDR_W-1:2] == b[EXT_ADDR_W-1:2];
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // register slave

   assign three_state = wait_state_control[BIT_ACCESS_STATE_SEL];
   assign wait_mode   = {wait_state_control[BIT_WAIT_MODE_SEL_HI],
                         wait_state_control[BIT_WAIT_MODE_SEL_LO]};

   // write address and data are taken in either order; one write outstanding
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         aw_addr       <= '0;
         w_byte        <= 8'h00;
         w_lane0       <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_addr       <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_awready <= 1'b1;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_byte       <= s_axi_wdata[7:0];
            w_lane0      <= s_axi_wstrb[0];
            s_axi_wready <= 1'b0;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_wready <= 1'b1;
         end
      end
   end

   // register update and write response; the status word is read only
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         external_bus_control <= EXTERNAL_BUS_CONTROL_RST;
         wait_state_control   <= WAIT_STATE_CONTROL_RST;
         system_control       <= SYSTEM_CONTROL_RST;
         s_axi_bvalid         <= 1'b0;
         s_axi_bresp          <= RESP_OKAY;
      end else if (!s_axi_awready && !s_axi_wready && !s_axi_bvalid) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= RESP_OKAY;
         unique case (aw_addr)
            OFS_EXTERNAL_BUS_CONTROL: if (w_lane0) external_bus_control <= w_byte;
            OFS_WAIT_STATE_CONTROL:   if (w_lane0) wait_state_control <= w_byte;
            OFS_SYSTEM_CONTROL:       if (w_lane0) system_control <= w_byte;
            OFS_BUS_STATUS:           s_axi_bresp <= RESP_OKAY;
            default:                  s_axi_bresp <= RESP_SLVERR;
         endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // read channel answers one cycle after the address is taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rresp   <= RESP_OKAY;
         unique case (s_axi_araddr)
            OFS_EXTERNAL_BUS_CONTROL: s_axi_rdata <= {24'h000000, external_bus_control};
            OFS_WAIT_STATE_CONTROL:   s_axi_rdata <= {24'h000000, wait_state_control};
            OFS_SYSTEM_CONTROL:       s_axi_rdata <= {24'h000000, system_control};
            OFS_BUS_STATUS:           s_axi_rdata <= {28'h0000000, state == ST_BURST,
                                                      state != ST_IDLE, dtc_grant, cpu_grant};
            default: begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin input synchronisers

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wait_meta_n <= 1'b1;
         wait_sync_n <= 1'b1;
      end else begin
         wait_meta_n <= wait_request_n;
         wait_sync_n <= wait_meta_n;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // arbitration and request selection

   // a new master is picked only from idle, so a cycle in flight keeps its owner
   always_comb begin
      pick_dtc = dtc_grant;
      if (state == ST_IDLE) begin
         if (dtc_req) begin
            pick_dtc = 1'b1;
         end else if (cpu_req) begin
            pick_dtc = 1'b0;
         end
      end
      r_req   = pick_dtc ? dtc_req   : cpu_req;
      r_we    = pick_dtc ? dtc_write : cpu_write;
      r_addr  = pick_dtc ? dtc_addr  : cpu_addr;
      r_wdata = pick_dtc ? dtc_wdata : cpu_wdata;
   end

   // the acked request is still visible for one cycle and must not restart
   assign ack_pend   = cpu_ack | dtc_ack;
   assign wait_pin   = three_state && !wait_sync_n;
   assign prog_waits = (wait_mode == WAIT_MODE_PROGRAM) || (wait_mode == WAIT_MODE_PIN);
   assign pin_waits  = (wait_mode == WAIT_MODE_PIN) || (wait_mode == WAIT_MODE_PIN_AUTO);
   assign burst_last = external_bus_control[BIT_BURST_WORD_LIMIT_SEL] ?
                       BURST_LAST_8 : BURST_LAST_4;
   assign burst_ok   = r_req && !r_we && (beat != burst_last) &&
                       same_block(r_addr, ext_addr,
                                  external_bus_control[BIT_BURST_WORD_LIMIT_SEL]);

   ////////////////////////////////////////////////////////////////////////////
   // cycle sequencer

   always_comb begin
      next_state    = state;
      next_wait_cnt = wait_cnt;
      next_beat     = beat;
      next_bphase   = bphase;
      done          = 1'b0;
      unique case (state)
         ST_IDLE: begin
            if (r_req && !ack_pend) begin
               next_wait_cnt = {wait_state_control[BIT_PROGRAM_WAIT_COUNT_HI],
                                wait_state_control[BIT_PROGRAM_WAIT_COUNT_LO]};
               if (r_we && last_read &&
                   external_bus_control[BIT_IDLE_INSERT_AFTER_READ]) begin
                  next_state = ST_GAP;
               end else begin
                  next_state = ST_T1;
               end
            end
         end
         ST_GAP: next_state = ST_T1;
         ST_T1:  next_state = ST_T2;
         ST_T2: begin
            if (!three_state) begin
               done = 1'b1;
            end else if ((prog_waits && wait_cnt != 2'h0) || (pin_waits && wait_pin)) begin
               next_state = ST_TW;
            end else begin
               next_state = ST_T3;
            end
         end
         ST_TW: begin
            if (prog_waits && wait_cnt != 2'h0) begin
               next_wait_cnt = wait_cnt - 2'h1;
               next_state    = (wait_cnt != 2'h1 || (pin_waits && wait_pin)) ? ST_TW : ST_T3;
            end else begin
               next_state = (pin_waits && wait_pin) ? ST_TW : ST_T3;
            end
         end
         ST_T3: done = 1'b1;
         ST_BHOLD: begin
            if (!ack_pend) begin
               if (burst_ok) begin
                  next_state  = ST_BURST;
                  next_beat   = beat + 3'h1;
                  next_bphase = 1'b0;
               end else begin
                  next_state = ST_IDLE;
               end
            end
         end
         ST_BURST: begin
            if (bphase == external_bus_control[BIT_BURST_CYCLE_LENGTH_SEL]) begin
               done = 1'b1;
            end else begin
               next_bphase = 1'b1;
            end
         end
      endcase
      if (done) begin
         if (external_bus_control[BIT_BURST_ROM_ENABLE] && !cur_we) begin
            next_state = ST_BHOLD;
            if (state != ST_BURST) begin
               next_beat = 3'h0;
            end
         end else begin
            next_state = ST_IDLE;
         end
      end
   end

   // values of the coming cycle, so every pin below is a plain flip-flop
   assign load        = (next_state == ST_T1 && state != ST_T1) ||
                        (next_state == ST_BURST && state == ST_BHOLD);
   assign next_we     = load ? r_we : cur_we;
   assign next_addr   = load ? r_addr : ext_addr;
   assign active      = !(next_state == ST_IDLE || next_state == ST_GAP);
   assign write_phase = next_state == ST_T2 || next_state == ST_TW || next_state == ST_T3;

   // sequencer state and cycle bookkeeping
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state     <= ST_IDLE;
         wait_cnt  <= 2'h0;
         beat      <= 3'h0;
         bphase    <= 1'b0;
         cur_we    <= 1'b0;
         last_read <= 1'b0;
         cpu_grant <= 1'b1;
         dtc_grant <= 1'b0;
      end else begin
         state    <= next_state;
         wait_cnt <= next_wait_cnt;
         beat     <= next_beat;
         bphase   <= next_bphase;
         cur_we   <= next_we;
         cpu_grant <= !pick_dtc;
         dtc_grant <= pick_dtc;
         if (done) begin
            last_read <= !cur_we;
         end else if (state == ST_IDLE && !ack_pend && !r_req) begin
            last_read <= 1'b0;  // a read only counts when the write follows at once
         end
      end
   end

   // external pins
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ext_addr         <= '0;
         ext_data_out     <= '0;
         ext_data_oe      <= 1'b0;
         addr_io_strobe_n <= 1'b1;
         read_strobe_n    <= 1'b1;
         store_strobe_n   <= 1'b1;
      end else begin
         if (load) begin
            ext_addr     <= r_addr;
            ext_data_out <= r_wdata;
         end
         if (system_control[BIT_PIN_FUNCTION_IO_MODE]) begin
            addr_io_strobe_n <= !(active && io_hit(next_addr,
                                  {external_bus_control[BIT_IO_RANGE_SELECT_HI],
                                   external_bus_control[BIT_IO_RANGE_SELECT_LO]}));
         end else begin
            addr_io_strobe_n <= !active;
         end
         read_strobe_n  <= !(active && !next_we);
         store_strobe_n <= !(write_phase && next_we);
         ext_data_oe    <= active && next_we;
      end
   end

   // completion pulse and read data; the data bus answers our own strobes, so it is
   // taken directly at the last state: a two-stage sampler would miss a 2-state read
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cpu_ack   <= 1'b0;
         dtc_ack   <= 1'b0;
         cpu_rdata <= '0;
         dtc_rdata <= '0;
      end else begin
         cpu_ack <= done && cpu_grant;
         dtc_ack <= done && dtc_grant;
         if (done && !cur_we && cpu_grant) begin
            cpu_rdata <= ext_data_in;
         end
         if (done && !cur_we && dtc_grant) begin
            dtc_rdata <= ext_data_in;
         end
      end
   end

endmodule // external_bus_controller

// File: testbench/ebc_props.sv
// port checks of the external bus controller
`timescale 1ns/10ps
module ebc_props (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic cpu_ack,
   input wire logic dtc_ack,
   input wire logic cpu_grant,
   input wire logic dtc_grant,
   input wire logic ext_data_oe,
   input wire logic read_strobe_n,
   input wire logic store_strobe_n
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   ////////////////////////////////////////
   // ownership and completion
   AST_ONE_OWNER: assert property (!(cpu_grant && dtc_grant))
      else $error("both masters own the bus");
   AST_CPU_ACK: assert property (cpu_ack |-> cpu_grant && !dtc_ack)
      else $error("cpu ack without grant");
   AST_DTC_ACK: assert property (dtc_ack |-> dtc_grant)
      else $error("transfer ack without grant");
   AST_ACK_PULSE: assert property ((cpu_ack || dtc_ack) |=> !cpu_ack && !dtc_ack)
      else $error("ack longer than one cycle");
   AST_HOLD_OWNER: assert property (!read_strobe_n && $past(!read_strobe_n)
      |-> $stable(dtc_grant)) else $error("owner changed inside a cycle");
   // strobes: never both, and data is driven before the store strobe falls
   AST_RD_WR_EXCL: assert property (!read_strobe_n |-> store_strobe_n)
      else $error("read and store strobe together");
   AST_WR_DRIVES: assert property (!store_strobe_n |-> ext_data_oe)
      else $error("store strobe without data drive");
   AST_WR_AFTER_OE: assert property ($fell(store_strobe_n) |-> $past(ext_data_oe))
      else $error("store strobe fell before data drive");
   cover property (dtc_ack);
   cover property (cpu_ack);
   cover property ($fell(store_strobe_n));
endmodule // ebc_props
bind external_bus_controller ebc_props u_chk (.aclk, .aresetn, .cpu_ack, .dtc_ack, .cpu_grant,
   .dtc_grant, .ext_data_oe, .read_strobe_n, .store_strobe_n);

// File: testbench/ext_mem_model.sv
// external memory model: read data from the address, optional wait request
`timescale 1ns/10ps
module ext_mem_model (
   input  wire logic        aclk,
   input  wire logic [15:0] ext_addr,
   input  wire logic        read_strobe_n,
   input  wire logic        slow,
   output logic      [7:0]  ext_data_in,
   output logic             wait_request_n
);
   logic [7:0] last = 8'h00;
   logic [2:0] held = 3'h0;
   // released bus shows the inverse of the last byte, so stale data never matches
   assign ext_data_in = read_strobe_n ? ~last : ext_addr[7:0] ^ 8'h5A;
   // a slow device asks to wait during the first three states of a read
   assign wait_request_n = !(slow && !read_strobe_n && held < 3'h3);
   // state count saturates, so a long burst does not wrap into a new wait
   always_ff @(posedge aclk) begin
      last <= ext_data_in;
      held <= read_strobe_n ? 3'h0 : (held == 3'h7 ? held : held + 3'h1);
   end
endmodule // ext_mem_model

// File: testbench/external_bus_controller_tb_top.sv
// self-checking bench of the external bus controller
`timescale 1ns/10ps
module external_bus_controller_tb_top;
   logic aclk = 0, aresetn = 0, slow = 0;
   logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0, rd;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata, q;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
   logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs;
   logic cpu_req = 0, cpu_write = 0, dtc_req = 0, dtc_write = 0, s_axi_rvalid;
   logic [15:0] cpu_addr = '0, dtc_addr = '0, ext_addr;
   logic [7:0] cpu_wdata = '0, dtc_wdata = '0, cpu_rdata, dtc_rdata, ext_data_out, ext_data_in;
   logic cpu_ack, dtc_ack, cpu_grant, dtc_grant, ext_data_oe, wait_request_n, as_seen, wr_ok;
   logic chain = 1'b0;
   logic addr_io_strobe_n, read_strobe_n, store_strobe_n;
   int err_total = 0, checks_done = 0, cyc = 0, n;
   ////////////////////////////////////////
   always #10 aclk = ~aclk;
   external_bus_controller dut_u (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .cpu_req, .cpu_write, .cpu_addr, .cpu_wdata, .cpu_ack, .cpu_rdata,
      .cpu_grant, .dtc_req, .dtc_write, .dtc_addr, .dtc_wdata, .dtc_ack, .dtc_rdata, .dtc_grant,
      .ext_addr, .ext_data_out, .ext_data_oe, .ext_data_in, .addr_io_strobe_n,
      .read_strobe_n, .store_strobe_n, .wait_request_n);
   ext_mem_model mem_u (.aclk, .ext_addr, .read_strobe_n, .slow, .ext_data_in, .wait_request_n);
   // hang guard, far above the few hundred cycles the run needs
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_total++;
         conclude;
      end
   end
   // compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // one AXI4-Lite transfer; each channel released at its own handshake
   task automatic axi(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge aclk);
      if (w) begin
         s_axi_awaddr <= a;
         s_axi_wdata <= d;
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid <= 1'b1;
         s_axi_bready <= 1'b1;
      end else begin
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'b1;
         s_axi_rready <= 1'b1;
      end
      do begin
         @(posedge aclk);
         k++;
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while ((w ? s_axi_bvalid : s_axi_rvalid) !== 1'b1 && k < 50);
      q = s_axi_rdata;
      rs = w ? s_axi_bresp : s_axi_rresp;
      s_axi_bready <= 1'b0;
      s_axi_rready <= 1'b0;
   endtask
   // one cpu access: cycles from launch to ack, strobe seen, write data seen
   task automatic acc(input logic w, input logic [15:0] a);
      n = 0;
      as_seen = 0;
      wr_ok = 0;
      @(posedge aclk);
      cpu_req <= 1'b1;
      cpu_write <= w;
      cpu_addr <= a;
      cpu_wdata <= ~a[7:0];
      do begin
         @(posedge aclk);
         #1;
         n++;
         if (addr_io_strobe_n === 1'b0) as_seen = 1;
         if (!store_strobe_n && ext_data_oe && ext_data_out === ~a[7:0]) wr_ok = 1;
      end while (cpu_ack !== 1'b1 && n < 40);
      rd = cpu_rdata;
      if (!chain) begin
         @(posedge aclk);
         cpu_req <= 1'b0;
      end
   endtask
   ////////////////////////////////////////
   // reset values and unmapped offsets; reserved bits always written as reset
   task automatic t_regs;
      axi(0, 8'h00, 0);
      chk(q, 32'h000000D3);
      axi(0, 8'h04, 0);
      chk(q, 32'h000000F3);
      axi(0, 8'h10, 0);
      chk(rs, 2'h2);
      axi(1, 8'h14, 1);
      chk(rs, 2'h2);
      $display("regs done");
   endtask
   // 2-state read ignores a wait request
   task automatic t_two;
      axi(1, 8'h00, 8'h93);
      axi(1, 8'h04, 8'hE0);
      slow <= 1'b1;
      acc(0, 16'h1234);
      chk(n, 3);
      chk(as_seen, 1);
      chk(rd, 8'h6E);
      slow <= 1'b0;
      $display("two-state done");
   endtask
   // every wait mode and count of a 3-state access
   task automatic t_wait;
      logic [7:0] mv [7] = '{8'hF0, 8'hF1, 8'hF2, 8'hF3, 8'hF7, 8'hFF, 8'hFA};
      int ev [7] = '{4, 5, 6, 7, 4, 4, 6};
      foreach (mv[i]) begin
         axi(1, 8'h04, mv[i]);
         acc(0, 16'h0200);
         chk(n, ev[i]);
      end
      axi(1, 8'h04, 8'hF9);
      slow <= 1'b1;
      acc(0, 16'h0200);
      chk(n > 5, 1);
      slow <= 1'b0;
      $display("wait done");
   endtask
   // write right after read, idle state off then on
   task automatic t_idle;
      axi(1, 8'h04, 8'hE0);
      for (int i = 0; i < 2; i++) begin
         axi(1, 8'h00, 8'h93 | (i << 6));
         chain = 1'b1;
         acc(0, 16'h0010);
         chain = 1'b0;
         acc(1, 16'h0020);
         chk(n, 3 + i);
         chk(wr_ok, 1);
      end
      $display("idle done");
   endtask
   // io select strobe inside and outside each range
   task automatic t_io;
      axi(1, 8'h08, 1);
      for (int r = 0; r < 4; r++) begin
         axi(1, 8'h00, 8'h90 | r);
         acc(0, {6'h3F, 2'(r), 8'h10});
         chk(as_seen, 1);
         acc(0, {6'h3F, 2'(r + 1), 8'h10});
         chk(as_seen, 0);
      end
      axi(1, 8'h08, 0);
      $display("io done");
   endtask
   // both masters ask at one edge: transfer controller first, then cpu
   task automatic t_arb;
      @(posedge aclk);
      cpu_req <= 1'b1;
      cpu_addr <= 16'h0300;
      dtc_req <= 1'b1;
      dtc_addr <= 16'h0301;
      do @(posedge aclk); while (cpu_ack !== 1'b1 && dtc_ack !== 1'b1 && cyc < 19000);
      chk(dtc_ack, 1);
      chk(dtc_rdata, 8'h5B);
      dtc_req <= 1'b0;
      do @(posedge aclk); while (cpu_ack !== 1'b1 && cyc < 19000);
      chk(cpu_rdata, 8'h5A);
      cpu_req <= 1'b0;
      $display("arbitration done");
   endtask
   // burst rom: cycle length and word limit
   task automatic t_burst;
      int nb [2];
      for (int i = 0; i < 2; i++) begin
         axi(1, 8'h00, 8'hA3 | (i * 8'h18));
         chain = 1'b1;
         acc(0, 16'h0100);
         chk(n, 3);
         acc(0, 16'h0101);
         nb[i] = n;
         chk(rd, 8'h5B);
         acc(0, 16'h0103);
         chain = 1'b0;
         acc(0, 16'h0104);
         chk(n, i ? nb[i] : 4);
      end
      chk(nb[0] < 3, 1);
      chk(nb[1], nb[0] + 1);
      $display("burst done");
   endtask
   // main sequence
   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_regs;
      t_two;
      t_wait;
      t_idle;
      t_io;
      t_arb;
      t_burst;
      conclude;
   end
endmodule // external_bus_controller_tb_top
